// ### core/boot_loader_defs.svh
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH
// Clock and timing
`define CLK_HZ 40000000
`define FIRST_BLK_TIMEOUT_S 60
`define CRC_REQ_PERIOD_MS 3000
`define FIRST_BLK_CYC (64'(`FIRST_BLK_TIMEOUT_S) * 64'(`CLK_HZ))
`define CRC_REQ_CYC ((64'(`CRC_REQ_PERIOD_MS) * 64'(`CLK_HZ)) / 64'd1000)
// Block layout
`define BLK_BYTES 128
`define BLK_LAST_IDX 8'h83
`define BLK_DATA_END 8'h82
`define BLK_CRC_HI_IDX 8'h82
// Characters and CRC polynomial
`define ASCII_CR 8'h0d
`define KEY_UPDATE 8'h31
`define KEY_RUN 8'h32
`define XM_SOH 8'h01
`define XM_EOT 8'h04
`define XM_ACK 8'h06
`define XM_NAK 8'h15
`define XM_CAN 8'h18
`define XM_CRC_REQ 8'h43
`define CRC_POLY 16'h1021
`endif

// ### core/boot_pkg.sv
package boot_pkg;
  typedef enum logic [3:0] {
    ST_BOOT = 4'h0,
    ST_WAIT_REL = 4'h1,
    ST_WAIT_CR = 4'h2,
    ST_APP = 4'h3,
    ST_SEND = 4'h4,
    ST_MENU = 4'h5,
    ST_XM_WAIT = 4'h6,
    ST_XM_BLK = 4'h7,
    ST_XM_CHK = 4'h8,
    ST_XM_FLASH = 4'h9,
    ST_XM_ACK = 4'ha
  } state_e;
  typedef enum logic [1:0] {
    MSG_MENU = 2'h0,
    MSG_DONE = 2'h1,
    MSG_ABORT = 2'h2
  } msg_e;
  typedef struct packed {
    state_e state;
    msg_e msg;
    logic [5:0] idx;
    logic [7:0] cnt;
    logic [7:0] blk_exp;
    logic [7:0] blk;
    logic [7:0] blk_inv;
    logic [15:0] crc;
    logic [15:0] crc_rx;
    logic [31:0] timer;
    logic [31:0] ctimer;
    logic first;
    logic [6:0] wptr;
    logic [23:0] addr;
    logic app_run;
    logic loaded;
    logic erase;
    logic commit;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [1:0] bcnt;
  } st_s;
endpackage : boot_pkg

// ### core/serial_bootloader_update.sv
// What this block does
// - On good entry send menu, take commands
// - No valid image: always start loader
// - Application entry command returns to application only via character 2 after a completed load
// - Talk over UART or SPI, host clocks SPI
// - Show prompt; host waits for it
// - Character 1 starts CRC XModem update
// - Completion string; character 2 runs new firmware
// - Failed load: abort string, back to menu
// - Abort if no first block within minute
// - Reset during transfer fails the load
// - Abort on file or flash error
`include "boot_loader_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_bootloader_update #(
  parameter logic [31:0] FIRST_TO_CYC = 32'(`FIRST_BLK_CYC),
  parameter logic [31:0] CREQ_CYC = 32'(`CRC_REQ_CYC)
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic din_level, // Serial data in line level
  input wire logic host_sleep_request, // Sleep request pin
  input wire logic rts, // RTS pin
  input wire logic image_valid, // Valid application present
  input wire logic app_enter_req, // Application asks for loader
  input wire logic spi_sel, // 1: SPI port, 0: UART
  input wire logic uart_rx_valid, // UART byte in
  input wire logic [7:0] uart_rx_data, // UART byte
  output logic uart_rx_ready, // UART byte taken
  input wire logic spi_rx_valid, // SPI byte in
  input wire logic [7:0] spi_rx_data, // SPI byte
  output logic spi_rx_ready, // SPI byte taken
  output logic uart_tx_valid, // UART byte out
  input wire logic uart_tx_ready, // UART transmitter free
  output logic spi_tx_valid, // SPI byte out
  input wire logic spi_tx_ready, // SPI shifter free
  output logic [7:0] tx_data, // Byte out, both ports
  output logic flash_valid, // Flash byte write request
  output logic [23:0] flash_addr, // Flash byte address
  output logic [7:0] flash_wdata, // Flash byte data
  input wire logic flash_ready, // Flash write done
  input wire logic flash_err, // Flash write failed
  output logic image_erase, // Old image invalidated
  output logic image_commit, // New image marked valid
  output logic app_run // Application in control
);
  localparam int MENU_N = 24;
  localparam int DONE_N = 10;
  localparam int ABORT_N = 9;
  localparam logic [8*MENU_N-1:0] MENU_T = "\r\n1 update\r\n2 run\r\nldr> ";
  localparam logic [8*DONE_N-1:0] DONE_T = "\r\ncomplete";
  localparam logic [8*ABORT_N-1:0] ABORT_T = "\r\naborted";

  boot_pkg::st_s q, d;
  logic [7:0] mem [0:`BLK_BYTES-1];
  logic rx_valid, rx_ready, rx_v, tx_ready, room, push, pop;
  logic [7:0] rx_d, pbyte, n_b0;
  logic mem_we;
  logic [6:0] mem_a;

  function automatic logic [7:0] msg_byte(input boot_pkg::msg_e m, input logic [5:0] i);
    case (m)
      boot_pkg::MSG_MENU: return MENU_T[8*(MENU_N-1-int'(i)) +: 8];
      boot_pkg::MSG_DONE: return DONE_T[8*(DONE_N-1-int'(i)) +: 8];
      default: return ABORT_T[8*(ABORT_N-1-int'(i)) +: 8];
    endcase
  endfunction : msg_byte

  function automatic logic [5:0] msg_last(input boot_pkg::msg_e m);
    case (m)
      boot_pkg::MSG_MENU: return 6'(MENU_N-1);
      boot_pkg::MSG_DONE: return 6'(DONE_N-1);
      default: return 6'(ABORT_N-1);
    endcase
  endfunction : msg_last

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++)
    begin
      r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_upd

  // Port steering
  assign rx_valid = spi_sel ? spi_rx_valid : uart_rx_valid;
  assign rx_d = spi_sel ? spi_rx_data : uart_rx_data;
  assign tx_ready = spi_sel ? spi_tx_ready : uart_tx_ready;
  assign room = q.bcnt != 2'd2;
  assign rx_ready = (q.state == boot_pkg::ST_WAIT_CR) || (q.state == boot_pkg::ST_MENU)
    || (q.state == boot_pkg::ST_XM_BLK) || (q.state == boot_pkg::ST_XM_WAIT && room);
  assign rx_v = rx_valid && rx_ready;
  assign uart_rx_ready = rx_ready && !spi_sel;
  assign spi_rx_ready = rx_ready && spi_sel;
  assign uart_tx_valid = (q.bcnt != 2'd0) && !spi_sel;
  assign spi_tx_valid = (q.bcnt != 2'd0) && spi_sel;
  assign tx_data = q.b0;
  assign pop = (q.bcnt != 2'd0) && tx_ready;
  assign flash_valid = q.state == boot_pkg::ST_XM_FLASH;
  assign flash_addr = q.addr;
  assign flash_wdata = mem[q.wptr];
  assign image_erase = q.erase;
  assign image_commit = q.commit;
  assign app_run = q.app_run;
  assign mem_we = q.state == boot_pkg::ST_XM_BLK && rx_v && q.cnt >= 8'h02 && q.cnt < `BLK_DATA_END;
  assign mem_a = 7'(q.cnt - 8'h02);

  always_comb
  begin
    d = q;
    push = 1'b0;
    pbyte = 8'h00;
    d.erase = 1'b0;
    d.commit = 1'b0;
    case (q.state)
      boot_pkg::ST_BOOT:
      begin
        if (!image_valid)
        begin
          d.state = boot_pkg::ST_SEND;
          d.msg = boot_pkg::MSG_MENU;
          d.idx = 6'h00;
        end
        else if (!din_level && !host_sleep_request && rts)
          d.state = boot_pkg::ST_WAIT_REL;
        else
        begin
          d.state = boot_pkg::ST_APP;
          d.app_run = 1'b1;
        end
      end
      boot_pkg::ST_WAIT_REL:
        if (din_level)
          d.state = boot_pkg::ST_WAIT_CR;
      boot_pkg::ST_WAIT_CR:
        if (rx_v && rx_d == `ASCII_CR)
        begin
          d.state = boot_pkg::ST_SEND;
          d.msg = boot_pkg::MSG_MENU;
          d.idx = 6'h00;
        end
      boot_pkg::ST_APP:
        if (app_enter_req)
        begin
          d.app_run = 1'b0;
          d.state = boot_pkg::ST_SEND;
          d.msg = boot_pkg::MSG_MENU;
          d.idx = 6'h00;
        end
      boot_pkg::ST_SEND:
        if (room)
        begin
          push = 1'b1;
          pbyte = msg_byte(q.msg, q.idx);
          if (q.idx != msg_last(q.msg))
            d.idx = q.idx + 6'h01;
          else if (q.msg == boot_pkg::MSG_MENU)
            d.state = boot_pkg::ST_MENU;
          else
          begin
            d.msg = boot_pkg::MSG_MENU;
            d.idx = 6'h00;
          end
        end
      boot_pkg::ST_MENU:
        if (rx_v)
        begin
          if (rx_d == `KEY_UPDATE)
          begin
            d.state = boot_pkg::ST_XM_WAIT;
            d.first = 1'b1;
            d.timer = 32'h0;
            d.ctimer = 32'h0;
            d.blk_exp = 8'h01;
            d.addr = 24'h0;
            d.loaded = 1'b0;
            d.erase = 1'b1;
          end
          else if (rx_d == `KEY_RUN && q.loaded)
          begin
            d.state = boot_pkg::ST_APP;
            d.app_run = 1'b1;
          end
          else
          begin
            d.state = boot_pkg::ST_SEND;
            d.msg = boot_pkg::MSG_MENU;
            d.idx = 6'h00;
          end
        end
      boot_pkg::ST_XM_WAIT:
      begin
        d.timer = q.timer + 32'h1;
        if (q.first && q.timer >= FIRST_TO_CYC - 32'h1)
        begin
          d.state = boot_pkg::ST_SEND;
          d.msg = boot_pkg::MSG_ABORT;
          d.idx = 6'h00;
        end
        else if (rx_v)
        begin
          case (rx_d)
            `XM_SOH:
            begin
              d.state = boot_pkg::ST_XM_BLK;
              d.cnt = 8'h00;
              d.crc = 16'h0;
              d.first = 1'b0;
            end
            `XM_EOT:
            begin
              push = 1'b1;
              pbyte = `XM_ACK;
              d.loaded = 1'b1;
              d.commit = 1'b1;
              d.state = boot_pkg::ST_SEND;
              d.msg = boot_pkg::MSG_DONE;
              d.idx = 6'h00;
            end
            `XM_CAN:
            begin
              d.state = boot_pkg::ST_SEND;
              d.msg = boot_pkg::MSG_ABORT;
              d.idx = 6'h00;
            end
            default: d.state = boot_pkg::ST_XM_WAIT;
          endcase
        end
        else if (q.first)
        begin
          if (q.ctimer == 32'h0)
          begin
            push = room;
            pbyte = `XM_CRC_REQ;
            d.ctimer = CREQ_CYC - 32'h1;
          end
          else
            d.ctimer = q.ctimer - 32'h1;
        end
      end
      boot_pkg::ST_XM_BLK:
        if (rx_v)
        begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == 8'h00)
            d.blk = rx_d;
          else if (q.cnt == 8'h01)
            d.blk_inv = rx_d;
          else if (q.cnt < `BLK_CRC_HI_IDX)
            d.crc = crc_upd(q.crc, rx_d);
          else if (q.cnt == `BLK_CRC_HI_IDX)
            d.crc_rx[15:8] = rx_d;
          else
          begin
            d.crc_rx[7:0] = rx_d;
            d.state = boot_pkg::ST_XM_CHK;
          end
        end
      boot_pkg::ST_XM_CHK:
        if (room)
        begin
          push = 1'b1;
          d.state = boot_pkg::ST_XM_WAIT;
          if (q.blk != ~q.blk_inv || q.crc != q.crc_rx)
            pbyte = `XM_NAK;
          else if (q.blk == q.blk_exp - 8'h01)
            pbyte = `XM_ACK;
          else if (q.blk != q.blk_exp)
          begin
            pbyte = `XM_CAN;
            d.state = boot_pkg::ST_SEND;
            d.msg = boot_pkg::MSG_ABORT;
            d.idx = 6'h00;
          end
          else
          begin
            push = 1'b0;
            d.state = boot_pkg::ST_XM_FLASH;
            d.wptr = 7'h00;
          end
        end
      boot_pkg::ST_XM_FLASH:
        if (flash_ready)
        begin
          if (flash_err)
          begin
            d.state = boot_pkg::ST_SEND;
            d.msg = boot_pkg::MSG_ABORT;
            d.idx = 6'h00;
          end
          else
          begin
            d.addr = q.addr + 24'h1;
            d.wptr = q.wptr + 7'h01;
            if (q.wptr == 7'(`BLK_BYTES - 1))
              d.state = boot_pkg::ST_XM_ACK;
          end
        end
      boot_pkg::ST_XM_ACK:
        if (room)
        begin
          push = 1'b1;
          pbyte = `XM_ACK;
          d.blk_exp = q.blk_exp + 8'h01;
          d.state = boot_pkg::ST_XM_WAIT;
        end
      default: d.state = boot_pkg::ST_BOOT;
    endcase
    // Two-entry transmit buffer
    n_b0 = pop ? q.b1 : q.b0;
    d.bcnt = q.bcnt - {1'b0, pop};
    d.b0 = n_b0;
    if (push)
    begin
      if (d.bcnt == 2'd0)
        d.b0 = pbyte;
      else
        d.b1 = pbyte;
      d.bcnt = d.bcnt + 2'd1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[mem_a] <= rx_d;
  end

  a_menu_after_cr: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_WAIT_CR && rx_v && rx_d == `ASCII_CR
    |=> q.state == boot_pkg::ST_SEND && q.msg == boot_pkg::MSG_MENU ##1 q.bcnt != 2'd0)
    else $error("menu not started after carriage return");
  a_no_image_boot: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_BOOT && !image_valid |=> q.state == boot_pkg::ST_SEND && !app_run)
    else $error("loader not started without image");
  a_app_no_return: assert property (@(posedge mclk) disable iff (sys_rst)
    app_run && app_enter_req |=> !app_run [*3])
    else $error("application regained control");
  a_port_steer: assert property (@(posedge mclk) disable iff (sys_rst)
    !(uart_tx_valid && spi_sel) && !(spi_tx_valid && !spi_sel) && !(uart_rx_ready && spi_rx_ready))
    else $error("byte on unselected port");
  a_menu_via_prompt: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_MENU && $past(q.state) != boot_pkg::ST_MENU
    |-> $past(q.state) == boot_pkg::ST_SEND && $past(q.msg) == boot_pkg::MSG_MENU)
    else $error("menu entered without prompt");
  a_update_start: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_MENU && rx_v && rx_d == `KEY_UPDATE
    |=> q.state == boot_pkg::ST_XM_WAIT && image_erase && q.first)
    else $error("update not started on key");
  a_run_loaded: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_MENU && rx_v && rx_d == `KEY_RUN && q.loaded |=> app_run)
    else $error("loaded firmware not started");
  a_abort_menu: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_SEND && q.msg == boot_pkg::MSG_ABORT && room && q.idx == msg_last(q.msg)
    |=> q.state == boot_pkg::ST_SEND && q.msg == boot_pkg::MSG_MENU && q.idx == 6'h00)
    else $error("abort did not return to menu");
  a_first_timeout: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_XM_WAIT && q.first && q.timer == FIRST_TO_CYC - 32'h1
    |=> q.state == boot_pkg::ST_SEND && q.msg == boot_pkg::MSG_ABORT)
    else $error("first block timeout missed");
  a_reset_fails: assert property (@(posedge mclk)
    sys_rst |=> q.state == boot_pkg::ST_BOOT && !q.loaded && !app_run)
    else $error("reset kept load state");
  a_flash_abort: assert property (@(posedge mclk) disable iff (sys_rst)
    flash_valid && flash_ready && flash_err |=> q.msg == boot_pkg::MSG_ABORT && !flash_valid)
    else $error("flash error not aborted");
  a_bad_crc_nak: assert property (@(posedge mclk) disable iff (sys_rst)
    q.state == boot_pkg::ST_XM_CHK && room && q.crc != q.crc_rx |=> q.state == boot_pkg::ST_XM_WAIT)
    else $error("bad block not refused");
endmodule : serial_bootloader_update
`default_nettype wire

// ### bench/boot_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module boot_host_model (
  input wire logic mclk, // Clock
  input wire logic spi_sel, // Port in use
  input wire logic slow, // Stall the module's output
  output logic uart_rx_valid, // UART byte to module
  output logic spi_rx_valid, // SPI byte to module
  output logic [7:0] rx_data, // Byte to module
  input wire logic uart_rx_ready, // UART byte taken
  input wire logic spi_rx_ready, // SPI byte taken
  input wire logic uart_tx_valid, // UART byte from module
  input wire logic spi_tx_valid, // SPI byte from module
  input wire logic [7:0] tx_data, // Byte from module
  output logic uart_tx_ready, // UART receiver free
  output logic spi_tx_ready // SPI master free
);
  logic [7:0] got[$];
  logic v;
  logic [2:0] n;
  assign uart_rx_valid = v && !spi_sel;
  assign spi_rx_valid = v && spi_sel;
  initial
  begin
    v = 1'b0;
    n = 3'h0;
    rx_data = 8'h00;
    uart_tx_ready = 1'b1;
    spi_tx_ready = 1'b1;
  end
  // No flow control lines, only the byte handshake paces traffic
  always @(negedge mclk)
  begin
    n <= n + 3'h1;
    uart_tx_ready <= !slow || n == 3'h0;
    spi_tx_ready <= !slow || n[0];
  end
  always @(posedge mclk)
    if (spi_sel ? spi_tx_valid && spi_tx_ready : uart_tx_valid && uart_tx_ready)
      got.push_back(tx_data);
  // Hold byte until taken; a released line shows the inverse
  task automatic send(input logic [7:0] b, output logic ok);
    int k;
    ok = 1'b0;
    @(negedge mclk);
    v = 1'b1;
    rx_data = b;
    for (k = 0; k < 400 && !ok; k++)
    begin
      #1;
      ok = spi_sel ? spi_rx_ready : uart_rx_ready;
      @(negedge mclk);
    end
    v = 1'b0;
    rx_data = ~b;
  endtask : send
endmodule : boot_host_model
`default_nettype wire

// ### bench/serial_bootloader_update_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_bootloader_update_bench;
  localparam int TO_CYC = 200;
  localparam string MENU = "\r\n1 update\r\n2 run\r\nldr> ";
  logic mclk = 1'b0, sys_rst = 1'b1, din_level = 1'b1, host_sleep_request = 1'b1, rts = 1'b0;
  logic image_valid = 1'b1, app_enter_req = 1'b0, spi_sel = 1'b0, slow = 1'b0;
  logic flash_ready = 1'b0, flash_err = 1'b0;
  logic uart_rx_valid, spi_rx_valid, uart_rx_ready, spi_rx_ready, uart_tx_valid, spi_tx_valid;
  logic uart_tx_ready, spi_tx_ready, flash_valid, image_erase, image_commit, app_run;
  logic [7:0] rx_data, tx_data, flash_wdata;
  logic [23:0] flash_addr, waddr;
  logic [31:0] seed = 32'h00016af1, dseed = 32'h00016af1, exp_wr[$];
  int err_count = 0, total_checks = 0, cyc = 0, wr_cnt = 0, err_at = -1, n_erase = 0, n_commit = 0, t0;
  serial_bootloader_update #(.FIRST_TO_CYC(32'd200), .CREQ_CYC(32'd20)) u_dut (.mclk, .sys_rst, .din_level,
    .host_sleep_request, .rts, .image_valid, .app_enter_req, .spi_sel, .uart_rx_valid, .uart_rx_data(rx_data),
    .uart_rx_ready, .spi_rx_valid, .spi_rx_data(rx_data), .spi_rx_ready, .uart_tx_valid, .uart_tx_ready,
    .spi_tx_valid, .spi_tx_ready, .tx_data, .flash_valid, .flash_addr, .flash_wdata, .flash_ready, .flash_err,
    .image_erase, .image_commit, .app_run);
  boot_host_model u_host (.mclk, .spi_sel, .slow, .uart_rx_valid, .spi_rx_valid, .rx_data, .uart_rx_ready,
    .spi_rx_ready, .uart_tx_valid, .spi_tx_valid, .tx_data, .uart_tx_ready, .spi_tx_ready);
  initial
    forever #12.5 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      x = x[15] ? {x[14:0], 1'b0} ^ 16'h1021 : {x[14:0], 1'b0};
    return x;
  endfunction : crc_step
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic fail();
    err_count++;
    close_out();
  endtask : fail
  always @(negedge mclk)
  begin
    seed <= lfsr(seed);
    flash_ready <= seed[0] | seed[1];
    flash_err <= wr_cnt == err_at;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (image_erase === 1'b1)
      n_erase++;
    if (image_commit === 1'b1)
      n_commit++;
    if (flash_valid === 1'b1 && flash_ready === 1'b1)
    begin
      wr_cnt++;
      check({flash_addr, flash_wdata}, exp_wr.size() > 0 ? exp_wr.pop_front() : 32'h0000dead);
    end
  end
  task automatic get(output logic [7:0] b);
    int k;
    for (k = 0; k < 3000 && u_host.got.size() == 0; k++)
      @(posedge mclk);
    if (k == 3000)
      fail();
    b = u_host.got.pop_front();
  endtask : get
  // Optionally skips repeated transfer requests first
  task automatic expect_b(input logic [7:0] e, input bit skip);
    logic [7:0] b;
    get(b);
    while (skip && b === 8'h43)
      get(b);
    check({24'h0, b}, {24'h0, e});
  endtask : expect_b
  task automatic expect_str(input string s, input bit skip);
    for (int i = 0; i < s.len(); i++)
      expect_b(s[i], skip && i == 0);
  endtask : expect_str
  task automatic tx(input logic [7:0] b);
    logic ok;
    u_host.send(b, ok);
    if (!ok)
      fail();
  endtask : tx
  task automatic send_blk(input logic [7:0] n, input bit bad, input bit wr, input int len);
    logic [7:0] d;
    logic [15:0] c;
    c = 16'h0000;
    tx(8'h01);
    tx(n);
    tx(~n);
    for (int i = 0; i < len; i++)
    begin
      dseed = lfsr(dseed);
      d = dseed[7:0];
      c = crc_step(c, d);
      if (wr)
        exp_wr.push_back({waddr + 24'(i), d});
      tx(d);
    end
    if (wr)
      waddr += 24'd128;
    if (len == 128)
    begin
      tx(c[15:8]);
      tx(c[7:0] ^ {7'h0, bad});
    end
  endtask : send_blk
  task automatic do_reset(input logic iv, input logic entry, input logic sel);
    @(negedge mclk);
    sys_rst = 1'b1;
    spi_sel = sel;
    image_valid = iv;
    host_sleep_request = !entry;
    rts = 1'b1;
    din_level = !entry;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    u_host.got.delete();
    exp_wr.delete();
    waddr = 24'h0;
    repeat (4) @(negedge mclk);
    din_level = 1'b1;
  endtask : do_reset
  initial
  begin
    do_reset(1'b1, 1'b0, 1'b0);
    check(32'(app_run), 1);
    check(32'(u_host.got.size()), 0);
    app_enter_req = 1'b1;
    @(negedge mclk);
    app_enter_req = 1'b0;
    expect_str(MENU, 1'b0);
    check(32'(app_run), 0);
    do_reset(1'b1, 1'b1, 1'b0);
    tx(8'h78);
    repeat (5) @(negedge mclk);
    check(32'(u_host.got.size()), 0);
    tx(8'h0d);
    expect_str(MENU, 1'b0);
    slow = 1'b1;
    t0 = n_erase;
    tx(8'h31);
    expect_b(8'h43, 1'b0);
    check(32'(n_erase - t0), 1);
    send_blk(8'h01, 1'b0, 1'b1, 128);
    expect_b(8'h06, 1'b1);
    send_blk(8'h02, 1'b1, 1'b0, 128);
    expect_b(8'h15, 1'b0);
    send_blk(8'h02, 1'b0, 1'b1, 128);
    expect_b(8'h06, 1'b0);
    send_blk(8'h02, 1'b0, 1'b0, 128);
    expect_b(8'h06, 1'b0);
    check(32'(exp_wr.size()), 0);
    tx(8'h04);
    expect_b(8'h06, 1'b0);
    expect_str({"\r\ncomplete", MENU}, 1'b0);
    check(32'(n_commit), 1);
    tx(8'h32);
    repeat (4) @(negedge mclk);
    check(32'(app_run), 1);
    do_reset(1'b0, 1'b0, 1'b1);
    expect_str(MENU, 1'b0);
    tx(8'h31);
    t0 = cyc;
    expect_b(8'h0d, 1'b1);
    check(32'(cyc - t0 > TO_CYC - 4 && cyc - t0 < TO_CYC + 40), 1);
    expect_str({"\naborted", MENU}, 1'b0);
    tx(8'h31);
    err_at = wr_cnt + 5;
    send_blk(8'h01, 1'b0, 1'b1, 128);
    expect_str({"\r\naborted", MENU}, 1'b1);
    err_at = -1;
    exp_wr.delete();
    tx(8'h31);
    send_blk(8'h05, 1'b0, 1'b0, 128);
    expect_b(8'h18, 1'b1);
    expect_str({"\r\naborted", MENU}, 1'b0);
    tx(8'h31);
    tx(8'h18);
    expect_str({"\r\naborted", MENU}, 1'b1);
    tx(8'h31);
    send_blk(8'h01, 1'b0, 1'b0, 20);
    t0 = n_commit;
    do_reset(1'b0, 1'b0, 1'b1);
    expect_str(MENU, 1'b0);
    tx(8'h32);
    expect_str(MENU, 1'b0);
    check(32'(app_run), 0);
    check(32'(n_commit - t0), 0);
    close_out();
  end
endmodule : serial_bootloader_update_bench
`default_nettype wire
